// ===== core/ifr_out_sel.sv
`timescale 1ns/1ps
module ifr_out_sel (
	// Selection link
	ifr_if.sel_side lnk
);

	////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_out
			logic [6:0] code;
			always_comb begin
				code = lnk.out_codes[gi*7 +: 7];
				lnk.out_sel[gi] = 1'b0;
				if (code <= ifr_pkg::OUT_ECHO_LAST) begin
					if (ifr_pkg::OUT_ECHO_MASK[code[5:0]]) begin
						lnk.out_sel[gi] = lnk.func[code[5:0]];
					end
				end else begin
					case (code)
						// Fault line is normally closed: on while healthy
						ifr_pkg::OUT_FAULT:   lnk.out_sel[gi] = ~lnk.status[0];
						ifr_pkg::OUT_WARNING: lnk.out_sel[gi] = lnk.status[1];
						ifr_pkg::OUT_READY:   lnk.out_sel[gi] = lnk.status[2];
						ifr_pkg::OUT_MOVING:  lnk.out_sel[gi] = lnk.status[3];
						ifr_pkg::OUT_AT_HOME: lnk.out_sel[gi] = lnk.status[4];
						ifr_pkg::OUT_TIMING:  lnk.out_sel[gi] = lnk.status[5];
						ifr_pkg::OUT_AREA1:   lnk.out_sel[gi] = lnk.status[6];
						ifr_pkg::OUT_AREA2:   lnk.out_sel[gi] = lnk.status[7];
						default:              lnk.out_sel[gi] = 1'b0;
					endcase
				end
			end
		end
	endgenerate

endmodule : ifr_out_sel

// ===== core/ifr_pin_cond.sv
`timescale 1ns/1ps
module ifr_pin_cond (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Terminal link
	ifr_if.cond_side  lnk
);

	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] sync3_r;
	logic [3:0] state_r;

	////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_term
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
					state_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= lnk.pin_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					// Accept a change only once two stages agree
					if (sync2_r[gi] == sync3_r[gi]) begin
						state_r[gi] <= sync3_r[gi];
					end
				end
			end
			// Normally closed inverts the sense
			assign lnk.active[gi] = state_r[gi] ^ lnk.level_nc[gi];
		end
	endgenerate

endmodule : ifr_pin_cond

// ===== core/ifr_top.sv
// How it works
// - Four input terminals, each with own code.
// - Reset codes: limits, home sensor, stop.
// - Code zero leaves a terminal unused.
// - Codes one to seven request motion types.
// - Code seventeen drives excitation off request.
// - Code eighteen drives the stop function.
// - Code twenty-four drives fault clear.
// - Code twenty-seven drives tool limit release.
// - Codes 32 to 47 drive general bits.
// - Codes 48 to 53 form data number.
// - Outputs reset to fault and ready status.
// - Network bits reach the same functions.
// - Per-terminal level: open or closed sense.
// - Shared codes combine by logical OR; tool release ANDs terminal and network claims.
`timescale 1ns/1ps
module ifr_top (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Terminal pins
	input  wire logic        input_terminal_a,
	input  wire logic        input_terminal_b,
	input  wire logic        input_terminal_c,
	input  wire logic        input_terminal_d,
	output logic             output_terminal_a,
	output logic             output_terminal_b,
	// Input code configuration
	input  wire logic        in_code_wr,
	input  wire logic [1:0]  in_code_idx,
	input  wire logic [5:0]  in_code_val,
	// Logic level configuration
	input  wire logic        level_wr,
	input  wire logic [3:0]  level_val,
	// Output code configuration
	input  wire logic        out_code_wr,
	input  wire logic        out_code_idx,
	input  wire logic [6:0]  out_code_val,
	// Network inputs
	input  wire logic [63:0] net_func,
	input  wire logic        net_tool_release_assigned,
	// Drive status
	input  wire logic        status_fault,
	input  wire logic        status_warning,
	input  wire logic        status_ready,
	input  wire logic        status_moving,
	input  wire logic        status_at_home,
	input  wire logic        status_timing,
	input  wire logic        status_area1,
	input  wire logic        status_area2,
	// Configuration readback
	output logic [23:0]      in_codes,
	output logic [3:0]       level_nc,
	output logic [13:0]      out_codes,
	// Motion functions
	output logic             run_positive,
	output logic             run_negative,
	output logic             home_return,
	output logic             position_start,
	output logic             sequence_launch,
	output logic             inch_positive,
	output logic             inch_negative,
	output logic [5:0]       direct_position_select,
	// Control functions
	output logic             excitation_off_request,
	output logic             motion_stop,
	output logic             fault_clear,
	output logic             position_preset,
	output logic             tool_limit_release,
	// Data and general bits
	output logic [15:0]      general_bits,
	output logic [5:0]       data_number,
	// Sensors
	output logic             positive_limit_sensor,
	output logic             negative_limit_sensor,
	output logic             home_position_sensor,
	output logic             slit_sensor
);

	////////////////////////////////////////////////////////////////////////
	// Storage

	// Configuration
	logic [5:0]  in_code_r [4];
	logic [6:0]  out_code_r [2];
	logic [3:0]  level_nc_r;
	logic [5:0]  eff_code [4];

	// Function state
	logic [63:0] func_r;
	logic [63:0] func_nxt;
	logic [63:0] term_hit;

	// Tool release
	logic        tool_term_assigned;
	logic        tool_term_hit;
	logic        tool_term_ok;
	logic        tool_net_ok;
	logic        tool_nxt;
	logic        tool_r;

	// Output stage
	logic [1:0]  out_r;

	ifr_if lnk ();

	////////////////////////////////////////////////////////////////////////
	// Sub-blocks

	ifr_pin_cond u_cond (
		.ref_clk (ref_clk),
		.rst     (rst),
		.lnk     (lnk.cond_side)
	);

	ifr_out_sel u_sel (
		.lnk (lnk.sel_side)
	);

	// Terminal a sits at bit 0
	assign lnk.pin_raw  = {input_terminal_d, input_terminal_c,
	                       input_terminal_b, input_terminal_a};
	assign lnk.level_nc = level_nc_r;
	assign lnk.func     = func_r;
	assign lnk.status   = {status_area2, status_area1, status_timing, status_at_home,
	                       status_moving, status_ready, status_warning, status_fault};
	assign lnk.out_codes = {out_code_r[1], out_code_r[0]};

	////////////////////////////////////////////////////////////////////////
	// Input code registers

	// Any stored code is kept for readback; decode filters it later
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			in_code_r[0] <= ifr_pkg::RST_IN_CODE_A;
			in_code_r[1] <= ifr_pkg::RST_IN_CODE_B;
			in_code_r[2] <= ifr_pkg::RST_IN_CODE_C;
			in_code_r[3] <= ifr_pkg::RST_IN_CODE_D;
		end else if (in_code_wr) begin
			in_code_r[in_code_idx] <= in_code_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Logic level register

	// Applied after the filter, so a sense change needs no resync
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			level_nc_r <= ifr_pkg::RST_LEVEL_NC;
		end else if (level_wr) begin
			level_nc_r <= level_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output code registers

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_code_r[0] <= ifr_pkg::RST_OUT_CODE_A;
			out_code_r[1] <= ifr_pkg::RST_OUT_CODE_B;
		end else if (out_code_wr) begin
			out_code_r[out_code_idx] <= out_code_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Effective codes

	// Unknown and brake release codes fold to unused, so a stray write
	// cannot raise a function that this drive does not have
	genvar gt;
	generate
		for (gt = 0; gt < 4; gt++) begin : g_eff
			assign eff_code[gt] = ifr_pkg::IN_VALID_MASK[in_code_r[gt]] ?
			                      in_code_r[gt] : ifr_pkg::IN_UNUSED;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Function decode

	genvar gf;
	generate
		for (gf = 0; gf < 64; gf++) begin : g_func
			always_comb begin
				term_hit[gf] = 1'b0;
				for (int t = 0; t < 4; t++) begin
					// Any active terminal with this code raises it
					if (eff_code[t] == 6'(gf) && lnk.active[t]) begin
						term_hit[gf] = 1'b1;
					end
				end
			end
			// Code zero never drives anything
			if (gf == 0) begin : g_none
				assign func_nxt[gf] = 1'b0;
			end else if (ifr_pkg::IN_VALID_MASK[gf]) begin : g_used
				// Network bits merge with terminals
				assign func_nxt[gf] = term_hit[gf] | net_func[gf];
			end else begin : g_idle
				assign func_nxt[gf] = 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Tool limit release

	// Release stays on unless a source claims it; claimed by both means
	// both must agree
	always_comb begin
		tool_term_assigned = 1'b0;
		tool_term_hit      = 1'b0;
		for (int t = 0; t < 4; t++) begin
			if (eff_code[t] == ifr_pkg::IN_TOOL_RELEASE) begin
				tool_term_assigned = 1'b1;
				if (lnk.active[t]) begin
					tool_term_hit = 1'b1;
				end
			end
		end
		tool_term_ok = tool_term_assigned ? tool_term_hit : 1'b1;
		tool_net_ok  = net_tool_release_assigned ?
		               net_func[ifr_pkg::IN_TOOL_RELEASE] : 1'b1;
		tool_nxt     = tool_term_ok & tool_net_ok;
	end

	////////////////////////////////////////////////////////////////////////
	// Function registers

	// One edge of latency for every source keeps all bits aligned
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			func_r <= 64'h0000_0000_0000_0000;
		end else begin
			func_r <= func_nxt;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tool_r <= 1'b0;
		end else begin
			tool_r <= tool_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output terminals

	// Registered so a code rewrite cannot glitch the terminals
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_r <= 2'h0;
		end else begin
			out_r <= lnk.out_sel;
		end
	end

	assign output_terminal_a = out_r[0];
	assign output_terminal_b = out_r[1];

	////////////////////////////////////////////////////////////////////////
	// Readback

	// Mirrors stored values so a write can be confirmed
	assign in_codes  = {in_code_r[3], in_code_r[2], in_code_r[1], in_code_r[0]};
	assign level_nc  = level_nc_r;
	assign out_codes = {out_code_r[1], out_code_r[0]};

	////////////////////////////////////////////////////////////////////////
	// Function outputs

	// Motion
	assign run_positive           = func_r[ifr_pkg::IN_RUN_POS];
	assign run_negative           = func_r[ifr_pkg::IN_RUN_NEG];
	assign home_return            = func_r[ifr_pkg::IN_HOME_RETURN];
	assign position_start         = func_r[ifr_pkg::IN_POS_START];
	assign sequence_launch        = func_r[ifr_pkg::IN_SEQ_LAUNCH];
	assign inch_positive          = func_r[ifr_pkg::IN_INCH_POS];
	assign inch_negative          = func_r[ifr_pkg::IN_INCH_NEG];
	assign direct_position_select = func_r[ifr_pkg::IN_DPS_BASE +: 6];

	// Control
	assign excitation_off_request = func_r[ifr_pkg::IN_EXCIT_OFF];
	assign motion_stop            = func_r[ifr_pkg::IN_STOP];
	assign fault_clear            = func_r[ifr_pkg::IN_FAULT_CLEAR];
	assign position_preset        = func_r[ifr_pkg::IN_POS_PRESET];
	assign tool_limit_release     = tool_r;

	// Data and general bits
	assign general_bits           = func_r[ifr_pkg::IN_GEN_BASE +: 16];
	assign data_number            = func_r[ifr_pkg::IN_DATA_BASE +: 6];

	// Sensors
	assign positive_limit_sensor  = func_r[ifr_pkg::IN_LIMIT_POS];
	assign negative_limit_sensor  = func_r[ifr_pkg::IN_LIMIT_NEG];
	assign home_position_sensor   = func_r[ifr_pkg::IN_HOME_SENSOR];
	assign slit_sensor            = func_r[ifr_pkg::IN_SLIT_SENSOR];

endmodule : ifr_top

// ===== inc/ifr_if.sv
`timescale 1ns/1ps
interface ifr_if;
	logic [3:0]  pin_raw;
	logic [3:0]  level_nc;
	logic [3:0]  active;
	logic [63:0] func;
	logic [7:0]  status;
	logic [13:0] out_codes;
	logic [1:0]  out_sel;

	modport core_side (
		output pin_raw,
		output level_nc,
		input  active,
		output func,
		output status,
		output out_codes,
		input  out_sel
	);
	modport cond_side (
		input  pin_raw,
		input  level_nc,
		output active
	);
	modport sel_side (
		input  func,
		input  status,
		input  out_codes,
		output out_sel
	);
endinterface : ifr_if

// ===== inc/ifr_pkg.sv
package ifr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int unsigned NUM_IN     = 4;
	localparam int unsigned NUM_OUT    = 2;
	localparam int unsigned IN_CODE_W  = 6;
	localparam int unsigned OUT_CODE_W = 7;
	localparam int unsigned NUM_FUNC   = 64;
	localparam int unsigned SYNC_DEPTH = 3;

	////////////////////////////////////////////////////////////////////////
	// Input function codes
	localparam logic [5:0] IN_UNUSED        = 6'h00;
	localparam logic [5:0] IN_RUN_POS       = 6'h01;
	localparam logic [5:0] IN_RUN_NEG       = 6'h02;
	localparam logic [5:0] IN_HOME_RETURN   = 6'h03;
	localparam logic [5:0] IN_POS_START     = 6'h04;
	localparam logic [5:0] IN_SEQ_LAUNCH    = 6'h05;
	localparam logic [5:0] IN_INCH_POS      = 6'h06;
	localparam logic [5:0] IN_INCH_NEG      = 6'h07;
	localparam logic [5:0] IN_DPS_BASE      = 6'h08;
	localparam logic [5:0] IN_BRAKE_FREE    = 6'h10;
	localparam logic [5:0] IN_EXCIT_OFF     = 6'h11;
	localparam logic [5:0] IN_STOP          = 6'h12;
	localparam logic [5:0] IN_FAULT_CLEAR   = 6'h18;
	localparam logic [5:0] IN_POS_PRESET    = 6'h19;
	localparam logic [5:0] IN_TOOL_RELEASE  = 6'h1B;
	localparam logic [5:0] IN_GEN_BASE      = 6'h20;
	localparam logic [5:0] IN_DATA_BASE     = 6'h30;
	localparam logic [5:0] IN_LIMIT_POS     = 6'h3C;
	localparam logic [5:0] IN_LIMIT_NEG     = 6'h3D;
	localparam logic [5:0] IN_HOME_SENSOR   = 6'h3E;
	localparam logic [5:0] IN_SLIT_SENSOR   = 6'h3F;

	// Codes that select a function; brake release is left out on purpose
	localparam logic [63:0] IN_VALID_MASK   = 64'hF03F_FFFF_0B06_3FFE;

	////////////////////////////////////////////////////////////////////////
	// Output function codes
	localparam logic [6:0] OUT_UNUSED       = 7'h00;
	localparam logic [6:0] OUT_ECHO_LAST    = 7'h3F;
	localparam logic [6:0] OUT_FAULT        = 7'h41;
	localparam logic [6:0] OUT_WARNING      = 7'h42;
	localparam logic [6:0] OUT_READY        = 7'h43;
	localparam logic [6:0] OUT_MOVING       = 7'h44;
	localparam logic [6:0] OUT_AT_HOME      = 7'h46;
	localparam logic [6:0] OUT_TIMING       = 7'h48;
	localparam logic [6:0] OUT_AREA1        = 7'h49;
	localparam logic [6:0] OUT_AREA2        = 7'h4A;
	localparam logic [63:0] OUT_ECHO_MASK   = 64'hF03F_FFFF_0007_3FFE;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [5:0] RST_IN_CODE_A    = IN_LIMIT_POS;
	localparam logic [5:0] RST_IN_CODE_B    = IN_LIMIT_NEG;
	localparam logic [5:0] RST_IN_CODE_C    = IN_HOME_SENSOR;
	localparam logic [5:0] RST_IN_CODE_D    = IN_STOP;
	localparam logic [6:0] RST_OUT_CODE_A   = OUT_FAULT;
	localparam logic [6:0] RST_OUT_CODE_B   = OUT_READY;
	localparam logic [3:0] RST_LEVEL_NC     = 4'h0;

endpackage : ifr_pkg

// ===== tb/ifr_bench.sv
`timescale 1ns/1ps
module ifr_bench;
	logic        ref_clk, rst, in_code_wr, level_wr, out_code_wr, out_code_idx, tool_claim;
	logic        in_a, in_b, in_c, in_d, out_a, out_b;
	logic [3:0]  pin_req, level_val, level_nc;
	logic [1:0]  in_code_idx;
	logic [5:0]  in_code_val, dps, dn;
	logic [6:0]  out_code_val;
	logic [7:0]  st;
	logic [13:0] out_codes;
	logic [15:0] gb;
	logic [23:0] in_codes;
	logic [63:0] net_func, fv;
	logic        rp, rn, hr, ps, sl, ip, inn, eo, ms, fc, pp, tl, lsp, lsn, hs, ss;
	logic [5:0]  code_tbl [22] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
		6'h07, 6'h08, 6'h0D, 6'h11, 6'h12, 6'h14, 6'h18, 6'h19, 6'h1B, 6'h20, 6'h2F,
		6'h30, 6'h35, 6'h3C, 6'h3F};
	logic [6:0]  stat_tbl [7] = '{7'h42, 7'h43, 7'h44, 7'h46, 7'h48, 7'h49, 7'h4A};
	int          mismatches;
	int          tests_run;

	// Function outputs laid out by input code
	assign fv = {ss, hs, lsn, lsp, 6'h00, dn, gb, 4'h0, tl, 1'b0, pp, fc, 5'h00, ms, eo,
		3'h0, dps, inn, ip, sl, ps, hr, rn, rp, 1'b0};

	ifr_host_model host (.pin_req(pin_req), .input_terminal_a(in_a),
		.input_terminal_b(in_b), .input_terminal_c(in_c), .input_terminal_d(in_d));

	ifr_top dut (.ref_clk(ref_clk), .rst(rst), .input_terminal_a(in_a),
		.input_terminal_b(in_b), .input_terminal_c(in_c), .input_terminal_d(in_d),
		.output_terminal_a(out_a), .output_terminal_b(out_b), .in_code_wr(in_code_wr),
		.in_code_idx(in_code_idx), .in_code_val(in_code_val), .level_wr(level_wr),
		.level_val(level_val), .out_code_wr(out_code_wr), .out_code_idx(out_code_idx),
		.out_code_val(out_code_val), .net_func(net_func),
		.net_tool_release_assigned(tool_claim), .status_fault(st[0]),
		.status_warning(st[1]), .status_ready(st[2]), .status_moving(st[3]),
		.status_at_home(st[4]), .status_timing(st[5]), .status_area1(st[6]),
		.status_area2(st[7]), .in_codes(in_codes), .level_nc(level_nc),
		.out_codes(out_codes), .run_positive(rp), .run_negative(rn), .home_return(hr),
		.position_start(ps), .sequence_launch(sl), .inch_positive(ip),
		.inch_negative(inn), .direct_position_select(dps), .excitation_off_request(eo),
		.motion_stop(ms), .fault_clear(fc), .position_preset(pp),
		.tool_limit_release(tl), .general_bits(gb), .data_number(dn),
		.positive_limit_sensor(lsp), .negative_limit_sensor(lsn),
		.home_position_sensor(hs), .slit_sensor(ss));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic wr_code(input logic [1:0] idx, input logic [5:0] val);
		@(posedge ref_clk);
		in_code_wr  <= 1'b1;
		in_code_idx <= idx;
		in_code_val <= val;
		@(posedge ref_clk);
		in_code_wr  <= 1'b0;
	endtask : wr_code

	task automatic wr_level(input logic [3:0] val);
		@(posedge ref_clk);
		level_wr  <= 1'b1;
		level_val <= val;
		@(posedge ref_clk);
		level_wr  <= 1'b0;
	endtask : wr_level

	task automatic wr_out(input logic idx, input logic [6:0] val);
		@(posedge ref_clk);
		out_code_wr  <= 1'b1;
		out_code_idx <= idx;
		out_code_val <= val;
		@(posedge ref_clk);
		out_code_wr  <= 1'b0;
	endtask : wr_out

	// Pin path takes six edges, so eight covers it with margin
	task automatic drive(input logic [3:0] p, input logic [63:0] n, input logic c,
		input logic [7:0] s);
		@(posedge ref_clk);
		pin_req    <= p;
		net_func   <= n;
		tool_claim <= c;
		st         <= s;
		cyc(8);
	endtask : drive

	function automatic logic [63:0] on_exp(input logic [5:0] c);
		if (c == 6'h00 || c == 6'h14)
			return 64'h0800_0000;
		return (64'h1 << c) | 64'h0800_0000;
	endfunction : on_exp

	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		$display("ERROR watchdog expected done seen hang");
		finish_test();
	end

	initial begin
		{rst, pin_req, in_code_wr, in_code_idx, in_code_val} = {1'b1, 13'h0000};
		{level_wr, level_val, out_code_wr, out_code_idx, out_code_val} = 14'h0000;
		{net_func, tool_claim, st} = {65'h0, 8'h04};
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(4);
		chk("in_codes", {6'h12, 6'h3E, 6'h3D, 6'h3C}, in_codes);
		chk("level_nc", 4'h0, level_nc);
		chk("out_codes", {7'h43, 7'h41}, out_codes);
		chk("out terminals", 2'b11, {out_b, out_a});
		drive(4'h9, 64'h0, 1'b0, 8'h05);
		chk("default functions", 64'h1000_0000_0804_0000, fv);
		chk("out terminals", 2'b10, {out_b, out_a});
		$display("test defaults done");
		// Brake release code is never written here
		foreach (code_tbl[i]) begin
			wr_code(2'h1, code_tbl[i]);
			drive(4'h2, 64'h0, 1'b0, 8'h04);
			chk("function on", on_exp(code_tbl[i]), fv);
			drive(4'h0, 64'h0, 1'b0, 8'h04);
			chk("function off", {36'h0, code_tbl[i] != 6'h1B, 27'h0}, fv);
		end
		$display("test code table done");
		wr_level(4'h1);
		drive(4'h0, 64'h0, 1'b0, 8'h04);
		chk("level_nc", 4'h1, level_nc);
		chk("closed contact", 64'h1000_0000_0800_0000, fv);
		wr_level(4'h0);
		wr_code(2'h0, 6'h12);
		drive(4'h1, 64'h0, 1'b0, 8'h04);
		chk("shared stop a", 64'h0804_0000, fv);
		drive(4'h8, 64'h0, 1'b0, 8'h04);
		chk("shared stop d", 64'h0804_0000, fv);
		$display("test level and sharing done");
		drive(4'h0, 64'h0035_A5A5_0004_0020, 1'b0, 8'h04);
		chk("network bits", 64'h0035_A5A5_0804_0020, fv);
		drive(4'h0, 64'h0035_A5A5_0004_0020, 1'b1, 8'h04);
		chk("claimed release off", 64'h0035_A5A5_0004_0020, fv);
		drive(4'h0, 64'h0800_0000, 1'b1, 8'h04);
		chk("claimed release on", 64'h0800_0000, fv);
		$display("test network done");
		foreach (stat_tbl[i]) begin
			wr_out(1'b1, stat_tbl[i]);
			drive(4'h0, 64'h0, 1'b0, 8'h01 << (i + 1));
			chk("status out", 1'b1, out_b);
			drive(4'h0, 64'h0, 1'b0, ~(8'h01 << (i + 1)));
			chk("status out off", 1'b0, out_b);
		end
		wr_out(1'b0, 7'h12);
		drive(4'h1, 64'h0, 1'b0, 8'h04);
		chk("echo out", 1'b1, out_a);
		wr_code(2'h2, 6'h05);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(4);
		chk("in_codes again", {6'h12, 6'h3E, 6'h3D, 6'h3C}, in_codes);
		chk("out_codes again", {7'h43, 7'h41}, out_codes);
		$display("test status and reset done");
		finish_test();
	end
endmodule : ifr_bench

// ===== tb/ifr_checker.sv
`timescale 1ns/1ps
module ifr_checker (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Configuration
	input wire logic        in_code_wr,
	input wire logic [1:0]  in_code_idx,
	input wire logic [5:0]  in_code_val,
	input wire logic [23:0] in_codes,
	input wire logic [3:0]  level_nc,
	input wire logic [13:0] out_codes,
	// Sources
	input wire logic [63:0] net_func,
	input wire logic        status_fault,
	input wire logic        status_ready,
	// Results
	input wire logic        output_terminal_a,
	input wire logic        output_terminal_b,
	input wire logic        motion_stop,
	input wire logic        excitation_off_request,
	input wire logic [15:0] general_bits,
	input wire logic [5:0]  data_number
);
	logic [1:0] up_cnt_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Output stage is one register deep; checks wait until up_cnt_r stops at 3 so its history is valid
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			up_cnt_r <= 2'h0;
		else if (up_cnt_r != 2'h3)
			up_cnt_r <= up_cnt_r + 2'h1;
	end

	sequence fault_sel_s;
		(out_codes[6:0] == 7'h41) [*3] ##0 (up_cnt_r == 2'h3);
	endsequence
	sequence ready_sel_s;
		(out_codes[13:7] == 7'h43) [*3] ##0 (up_cnt_r == 2'h3);
	endsequence

	reset_codes_a: assert property (
		$fell(rst) |-> in_codes == {6'h12, 6'h3E, 6'h3D, 6'h3C})
		else $error("input codes not at reset values");
	level_reset_a: assert property (
		$fell(rst) |-> level_nc == 4'h0)
		else $error("level setting not at reset value");
	out_reset_a: assert property (
		$fell(rst) |-> out_codes == {7'h43, 7'h41})
		else $error("output codes not at reset values");
	code_write_a: assert property (
		in_code_wr |=> in_codes[$past(in_code_idx) * 6 +: 6] == $past(in_code_val))
		else $error("input code write lost");
	net_stop_a: assert property (
		net_func[18] && !$past(rst) |=> motion_stop)
		else $error("network stop bit ignored");
	net_general_a: assert property (
		!$past(rst) |=> (general_bits & $past(net_func[47:32])) == $past(net_func[47:32]))
		else $error("network general bit ignored");
	net_data_a: assert property (
		!$past(rst) |=> (data_number & $past(net_func[53:48])) == $past(net_func[53:48]))
		else $error("network data bit ignored");
	idle_excit_a: assert property (
		!$past(rst) && $stable(in_codes) && !net_func[17] && in_codes[5:0] != 6'h11 &&
		in_codes[11:6] != 6'h11 && in_codes[17:12] != 6'h11 && in_codes[23:18] != 6'h11
		|=> !excitation_off_request)
		else $error("undriven excitation request active");
	fault_out_a: assert property (
		fault_sel_s |-> output_terminal_a == !$past(status_fault))
		else $error("fault output wrong");
	ready_out_a: assert property (
		ready_sel_s |-> output_terminal_b == $past(status_ready))
		else $error("ready output wrong");
endmodule : ifr_checker

bind ifr_top ifr_checker u_chk (
	.ref_clk(ref_clk), .rst(rst), .in_code_wr(in_code_wr), .in_code_idx(in_code_idx),
	.in_code_val(in_code_val), .in_codes(in_codes), .level_nc(level_nc),
	.out_codes(out_codes), .net_func(net_func), .status_fault(status_fault),
	.status_ready(status_ready), .output_terminal_a(output_terminal_a),
	.output_terminal_b(output_terminal_b), .motion_stop(motion_stop),
	.excitation_off_request(excitation_off_request), .general_bits(general_bits),
	.data_number(data_number)
);

// ===== tb/ifr_host_model.sv
`timescale 1ns/1ps
module ifr_host_model (
	// Requested contact states, bit 0 is terminal a
	input wire logic [3:0] pin_req,
	// Terminal pins
	output logic           input_terminal_a,
	output logic           input_terminal_b,
	output logic           input_terminal_c,
	output logic           input_terminal_d
);
	// Contacts are driven hard at all times; no floating level
	assign {input_terminal_d, input_terminal_c, input_terminal_b, input_terminal_a} = pin_req;
endmodule : ifr_host_model
